// ### hdl/scss_cfg.svh
// Offsets, field positions, reset values and rates of the clock selector
`ifndef SCSS_CFG_SVH
`define SCSS_CFG_SVH
`define SCSS_CLK_SYS_HZ 64'd125000000
`define SCSS_FAST_RC_HZ 64'd7370000
`define SCSS_LOW_POWER_RC_HZ 64'd32768
`define SCSS_FAST_RC_INC 32'((`SCSS_FAST_RC_HZ << 32) / `SCSS_CLK_SYS_HZ)
`define SCSS_LOW_POWER_RC_INC \
   32'((`SCSS_LOW_POWER_RC_HZ << 32) / `SCSS_CLK_SYS_HZ)
`define SCSS_TUNE_SHIFT 9
`define SCSS_DIV16_RATIO 9'h010
`define SCSS_ADDR_CLOCK_DIVISOR 8'h00
`define SCSS_ADDR_TUNE 8'h04
`define SCSS_ADDR_STATUS 8'h08
`define SCSS_POSTDIV_LSB 8
`define SCSS_POSTDIV_MSB 10
`define SCSS_TUNE_MSB 5
`define SCSS_POSTDIV_RST 3'h0
`define SCSS_TUNE_RST 6'h00
`define SCSS_ST_CHOICE_MSB 2
`define SCSS_ST_PMODE_LSB 4
`define SCSS_ST_PMODE_MSB 5
`define SCSS_ST_PLL_BIT 8
`define SCSS_ST_RSVD_BIT 9
`define SCSS_ST_ALT_BIT 10
`define SCSS_ST_RUN_BIT 11
`endif

// ### hdl/scss_pkg.sv
// Types shared by the clock source selector
package scss_pkg;
   typedef enum logic [2:0] {
      SCSS_FAST_RC = 3'b000,
      SCSS_FAST_RC_PLL_MODE = 3'b001,
      SCSS_PRIMARY = 3'b010,
      SCSS_PRIMARY_PLL = 3'b011,
      SCSS_RESERVED_CHOICE = 3'b100,
      SCSS_LOW_POWER_RC = 3'b101,
      SCSS_FAST_RC_DIVIDE_BY_16_MODE = 3'b110,
      SCSS_FAST_RC_DIVIDE_BY_N_MODE = 3'b111
   } scss_osc_choice_t;
   typedef enum logic [1:0] {
      SCSS_EXTERNAL_CLOCK_IN_MODE = 2'b00,
      SCSS_CRYSTAL_MODE = 2'b01,
      SCSS_HIGH_SPEED_CRYSTAL_MODE = 2'b10,
      SCSS_PRIMARY_OFF = 2'b11
   } scss_pmode_t;
   typedef enum logic [0:0] {
      SCSS_ST_SAMPLE = 1'b0,
      SCSS_ST_RUN = 1'b1
   } scss_state_t;
   typedef struct packed {
      logic osc_pin_alt_function_bit;
      scss_pmode_t primary_osc_mode_field;
      scss_osc_choice_t initial_osc_choice;
   } scss_cfg_word_t;
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [15:0] wdata;
   } scss_bus_req_t;
endpackage : scss_pkg

// ### hdl/scss_tick_nco.sv
// Phase accumulator that turns an increment into a tick stream
`timescale 1ns/1ns
`default_nettype none
module scss_tick_nco (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [31:0] inc,
   output logic tick
);
   logic [31:0] acc_r;
   logic tick_r;
   logic [32:0] acc_nxt;

   // Carry out of the accumulator marks one oscillator period
   assign acc_nxt = {1'b0, acc_r} + {1'b0, inc};

   // Accumulate every cycle
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         acc_r <= 32'h0000_0000;
         tick_r <= 1'b0;
      end else begin
         acc_r <= acc_nxt[31:0];
         tick_r <= acc_nxt[32];
      end
   end

   assign tick = tick_r;
endmodule : scss_tick_nco
`default_nettype wire

// ### hdl/scss_source_select.sv
// System clock source selection, post-divider, PLL and clock halving
//
// The register offsets and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "scss_cfg.svh"
module scss_source_select #(
   parameter logic [4:0] PLL_MULT = 5'd8
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire scss_pkg::scss_cfg_word_t cfg_word,
   input wire scss_pkg::scss_bus_req_t bus_req,
   output logic [15:0] bus_rdata,
   input wire logic osc_in_pin,
   output logic osc_out_o,
   output logic osc_out_oe_n,
   output logic xtal_drive_en,
   output logic oscillator_output_clock,
   output logic instruction_clock,
   output logic instr_tick,
   output logic peripheral_time_base,
   output logic low_power_rc_tick
);
   import scss_pkg::*;

   scss_state_t state_r;
   scss_cfg_word_t cfg_r;
   logic [2:0] postdiv_r;
   logic [5:0] tune_r;
   logic [15:0] rdata_r;
   logic fast_rc_tick;
   logic fast_rc_pll_tick;
   logic lp_tick;
   logic [31:0] fast_rc_inc;
   logic [31:0] fast_rc_pll_inc;
   logic [7:0] post_cnt_r;
   logic [7:0] post_last;
   logic divided_sel;
   logic pin_s1_r;
   logic pin_s2_r;
   logic pin_s3_r;
   logic pin_filt_r;
   logic pin_filt_d_r;
   logic pri_rise;
   logic pri_on;
   logic pri_crystal;
   logic [15:0] pri_per_cnt_r;
   logic [15:0] pri_period_r;
   logic [19:0] pll_acc_r;
   logic [19:0] pll_sum;
   logic pri_pll_tick_r;
   logic osc_tick_nxt;
   logic osc_tick_r;
   logic instr_clk_r;
   logic instr_tick_r;
   logic periph_clk_r;
   logic osc_out_r;
   logic osc_out_oe_n_r;
   logic xtal_drive_r;
   logic running;

   // Trimmed fast RC increment, one step is 1/512 of nominal
   function automatic logic [31:0] scss_tuned_inc(
      input logic [5:0] tune,
      input logic [4:0] mult
   );
      logic [31:0] step;
      logic [31:0] base;
      step = `SCSS_FAST_RC_INC >> `SCSS_TUNE_SHIFT;
      base = `SCSS_FAST_RC_INC + 32'({{26{tune[5]}}, tune} * step);
      return 32'(base * {27'h0000000, mult});
   endfunction : scss_tuned_inc

   // Last count value of a divide ratio
   function automatic logic [7:0] scss_div_last(input logic [8:0] ratio);
      logic [8:0] last;
      last = ratio - 9'h001;
      return last[7:0];
   endfunction : scss_div_last

   assign running = (state_r == SCSS_ST_RUN);

   // Catch the configuration word once, after reset release
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= SCSS_ST_SAMPLE;
         cfg_r <= '0;
      end else begin
         case (state_r)
            SCSS_ST_SAMPLE: begin
               cfg_r <= cfg_word;
               state_r <= SCSS_ST_RUN;
            end
            SCSS_ST_RUN: begin
               state_r <= SCSS_ST_RUN; // held until next reset
            end
            default: begin
               state_r <= SCSS_ST_SAMPLE;
            end
         endcase
      end
   end

   // Software control registers
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         postdiv_r <= `SCSS_POSTDIV_RST;
         tune_r <= `SCSS_TUNE_RST;
      end else if (bus_req.wr) begin
         if (bus_req.addr == `SCSS_ADDR_CLOCK_DIVISOR) begin
            postdiv_r <= bus_req.wdata[`SCSS_POSTDIV_MSB:`SCSS_POSTDIV_LSB];
         end
         if (bus_req.addr == `SCSS_ADDR_TUNE) begin
            tune_r <= bus_req.wdata[`SCSS_TUNE_MSB:0];
         end
      end
   end

   // Read data stands in the cycle after the read strobe only
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rdata_r <= 16'h0000;
      end else if (bus_req.rd) begin
         case (bus_req.addr)
            `SCSS_ADDR_CLOCK_DIVISOR: begin
               rdata_r <= 16'h0000;
               rdata_r[`SCSS_POSTDIV_MSB:`SCSS_POSTDIV_LSB] <= postdiv_r;
            end
            `SCSS_ADDR_TUNE: begin
               rdata_r <= {10'h000, tune_r};
            end
            `SCSS_ADDR_STATUS: begin
               rdata_r <= 16'h0000;
               rdata_r[`SCSS_ST_CHOICE_MSB:0] <= cfg_r.initial_osc_choice;
               rdata_r[`SCSS_ST_PMODE_MSB:`SCSS_ST_PMODE_LSB] <=
                  cfg_r.primary_osc_mode_field;
               rdata_r[`SCSS_ST_PLL_BIT] <=
                  (cfg_r.initial_osc_choice == SCSS_FAST_RC_PLL_MODE) ||
                  (cfg_r.initial_osc_choice == SCSS_PRIMARY_PLL);
               rdata_r[`SCSS_ST_RSVD_BIT] <=
                  (cfg_r.initial_osc_choice == SCSS_RESERVED_CHOICE);
               rdata_r[`SCSS_ST_ALT_BIT] <= cfg_r.osc_pin_alt_function_bit;
               rdata_r[`SCSS_ST_RUN_BIT] <= running;
            end
            default: begin
               rdata_r <= 16'h0000;
            end
         endcase
      end else begin
         rdata_r <= 16'h0000;
      end
   end

   // Internal RC oscillators as tick streams on the system clock
   assign fast_rc_inc = scss_tuned_inc(tune_r, 5'd1);
   assign fast_rc_pll_inc = scss_tuned_inc(tune_r, PLL_MULT);

   scss_tick_nco u_fast_rc_osc (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .inc(fast_rc_inc),
      .tick(fast_rc_tick)
   );

   scss_tick_nco u_fast_rc_pll (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .inc(fast_rc_pll_inc),
      .tick(fast_rc_pll_tick)
   );

   scss_tick_nco u_low_power_rc_osc (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .inc(`SCSS_LOW_POWER_RC_INC),
      .tick(lp_tick)
   );

   // Post-divider for the two divided fast RC modes
   assign divided_sel = running &&
      ((cfg_r.initial_osc_choice == SCSS_FAST_RC_DIVIDE_BY_N_MODE) ||
       (cfg_r.initial_osc_choice == SCSS_FAST_RC_DIVIDE_BY_16_MODE));
   assign post_last =
      (cfg_r.initial_osc_choice == SCSS_FAST_RC_DIVIDE_BY_16_MODE) ?
      scss_div_last(`SCSS_DIV16_RATIO) :
      scss_div_last(9'h002 << postdiv_r);

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         post_cnt_r <= 8'h00;
      end else if (divided_sel && fast_rc_tick) begin
         if (post_cnt_r >= post_last) begin
            post_cnt_r <= 8'h00;
         end else begin
            post_cnt_r <= post_cnt_r + 8'h01;
         end
      end
   end

   // Primary pin: three flops, a change counts once stages 2 and 3 agree
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pin_s1_r <= 1'b0;
         pin_s2_r <= 1'b0;
         pin_s3_r <= 1'b0;
         pin_filt_r <= 1'b0;
         pin_filt_d_r <= 1'b0;
      end else begin
         pin_s1_r <= osc_in_pin;
         pin_s2_r <= pin_s1_r;
         pin_s3_r <= pin_s2_r;
         if (pin_s2_r == pin_s3_r) begin
            pin_filt_r <= pin_s3_r;
         end
         pin_filt_d_r <= pin_filt_r;
      end
   end

   assign pri_rise = pin_filt_r && !pin_filt_d_r;
   assign pri_on = running &&
      ((cfg_r.initial_osc_choice == SCSS_PRIMARY) ||
       (cfg_r.initial_osc_choice == SCSS_PRIMARY_PLL)) &&
      (cfg_r.primary_osc_mode_field != SCSS_PRIMARY_OFF);
   assign pri_crystal = pri_on &&
      (cfg_r.primary_osc_mode_field != SCSS_EXTERNAL_CLOCK_IN_MODE);

   // Primary period measured in system clocks for the PLL
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pri_per_cnt_r <= 16'h0000;
         pri_period_r <= 16'h0000;
      end else if (pri_rise) begin
         pri_period_r <= pri_per_cnt_r;
         pri_per_cnt_r <= 16'h0001;
      end else if (pri_per_cnt_r != 16'hFFFF) begin
         pri_per_cnt_r <= pri_per_cnt_r + 16'h0001;
      end
   end

   // Primary PLL: PLL_MULT ticks per measured input period
   assign pll_sum = pll_acc_r + {15'h0000, PLL_MULT};

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pll_acc_r <= 20'h00000;
         pri_pll_tick_r <= 1'b0;
      end else if (pri_period_r == 16'h0000) begin
         pll_acc_r <= 20'h00000;
         pri_pll_tick_r <= 1'b0;
      end else if (pll_sum >= {4'h0, pri_period_r}) begin
         pll_acc_r <= pll_sum - {4'h0, pri_period_r};
         pri_pll_tick_r <= 1'b1;
      end else begin
         pll_acc_r <= pll_sum;
         pri_pll_tick_r <= 1'b0;
      end
   end

   // Oscillator output clock from the held selection
   always_comb begin
      osc_tick_nxt = 1'b0;
      if (running) begin
         case (cfg_r.initial_osc_choice)
            SCSS_FAST_RC: osc_tick_nxt = fast_rc_tick;
            SCSS_FAST_RC_PLL_MODE: osc_tick_nxt = fast_rc_pll_tick;
            SCSS_PRIMARY: osc_tick_nxt = pri_on && pri_rise;
            SCSS_PRIMARY_PLL: osc_tick_nxt = pri_on && pri_pll_tick_r;
            SCSS_LOW_POWER_RC: osc_tick_nxt = lp_tick;
            SCSS_FAST_RC_DIVIDE_BY_16_MODE,
            SCSS_FAST_RC_DIVIDE_BY_N_MODE: begin
               osc_tick_nxt = fast_rc_tick && (post_cnt_r >= post_last);
            end
            default: osc_tick_nxt = 1'b0; // reserved choice gives no clock
         endcase
      end
   end

   // Oscillator tick, then halving into instruction and peripheral clocks
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         osc_tick_r <= 1'b0;
         instr_clk_r <= 1'b0;
         instr_tick_r <= 1'b0;
         periph_clk_r <= 1'b0;
      end else begin
         osc_tick_r <= osc_tick_nxt;
         instr_tick_r <= osc_tick_r && !instr_clk_r;
         if (osc_tick_r) begin
            instr_clk_r <= !instr_clk_r;
            periph_clk_r <= !periph_clk_r;
         end
      end
   end

   // Second pin and crystal driver follow the held mode
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         osc_out_r <= 1'b0;
         osc_out_oe_n_r <= 1'b1;
         xtal_drive_r <= 1'b0;
      end else if (pri_crystal) begin
         osc_out_r <= !pin_filt_r;
         osc_out_oe_n_r <= 1'b0;
         xtal_drive_r <= 1'b1;
      end else if (running && !cfg_r.osc_pin_alt_function_bit) begin
         osc_out_r <= instr_clk_r;
         osc_out_oe_n_r <= 1'b0;
         xtal_drive_r <= 1'b0;
      end else begin
         osc_out_r <= 1'b0;
         osc_out_oe_n_r <= 1'b1;
         xtal_drive_r <= 1'b0;
      end
   end

   assign bus_rdata = rdata_r;
   assign osc_out_o = osc_out_r;
   assign osc_out_oe_n = osc_out_oe_n_r;
   assign xtal_drive_en = xtal_drive_r;
   assign oscillator_output_clock = osc_tick_r;
   assign instruction_clock = instr_clk_r;
   assign instr_tick = instr_tick_r;
   assign peripheral_time_base = periph_clk_r;
   assign low_power_rc_tick = lp_tick;

   a_cfg_held_run: assert property (@(posedge clk_sys) disable iff (!rst_n)
      running |=> $stable(cfg_r) && running)
      else $error("configuration changed after sampling");

   a_sample_first_edge: assert property (@(posedge clk_sys)
      disable iff (!rst_n)
      !running |=> running && (cfg_r == $past(cfg_word)))
      else $error("configuration not sampled at first edge");

   a_half_rate: assert property (@(posedge clk_sys) disable iff (!rst_n)
      $changed(instr_clk_r) |-> $past(osc_tick_r) &&
      (periph_clk_r == instr_clk_r))
      else $error("instruction clock not half the oscillator clock");

   a_divn_ratio: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (osc_tick_nxt && cfg_r.initial_osc_choice ==
       SCSS_FAST_RC_DIVIDE_BY_N_MODE) |->
      post_cnt_r >= scss_div_last(9'h002 << postdiv_r))
      else $error("divide-by-N tick at wrong count");

   a_div16_ratio: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (osc_tick_nxt && cfg_r.initial_osc_choice ==
       SCSS_FAST_RC_DIVIDE_BY_16_MODE) |-> post_cnt_r == 8'h0F)
      else $error("divide-by-16 tick at wrong count");

   a_internal_source: assert property (@(posedge clk_sys)
      disable iff (!rst_n)
      (running && cfg_r.initial_osc_choice == SCSS_LOW_POWER_RC) |->
      (osc_tick_nxt == lp_tick) && !xtal_drive_en)
      else $error("low-power source not routed");

   a_fast_rc_plain: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (running && cfg_r.initial_osc_choice == SCSS_FAST_RC) |->
      osc_tick_nxt == fast_rc_tick)
      else $error("fast RC source not routed");

   a_ext_no_drive: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (pri_on && cfg_r.primary_osc_mode_field ==
       SCSS_EXTERNAL_CLOCK_IN_MODE) |=> !xtal_drive_en)
      else $error("crystal driver on in external clock mode");

   a_alt_pin_free: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (running && !pri_crystal && cfg_r.osc_pin_alt_function_bit) |=>
      osc_out_oe_n)
      else $error("second pin driven with alternate function set");
endmodule : scss_source_select
`default_nettype wire

// ### tb/scss_source_select_tb.sv
// Self-checking testbench for the system clock source selector
`timescale 1ns/1ns
`default_nettype none
`include "scss_cfg.svh"
module scss_source_select_tb;
   import scss_pkg::*;
   localparam real FAST_RC_OSC = 7.37e6 / 125.0e6;
   localparam real LPR = 32768.0 / 125.0e6;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic osc_in_pin = 1'b0;
   logic osc_run = 1'b0;
   scss_cfg_word_t cfg_word = '0;
   scss_bus_req_t bus_req = '0;
   logic [15:0] bus_rdata;
   logic osc_out_o, osc_out_oe_n, xtal_drive_en, oscillator_output_clock;
   logic instruction_clock, instr_tick, peripheral_time_base;
   logic low_power_rc_tick;
   logic [15:0] rd;
   int fails = 0;
   int comparisons = 0;
   int n_osc, n_ins, n_rise, n_lp, n_bad, pin_cnt = 0;

   scss_source_select #(.PLL_MULT(5'd8)) i_dut (
      .clk_sys(clk_sys), .rst_n(rst_n), .cfg_word(cfg_word),
      .bus_req(bus_req), .bus_rdata(bus_rdata), .osc_in_pin(osc_in_pin),
      .osc_out_o(osc_out_o), .osc_out_oe_n(osc_out_oe_n),
      .xtal_drive_en(xtal_drive_en),
      .oscillator_output_clock(oscillator_output_clock),
      .instruction_clock(instruction_clock), .instr_tick(instr_tick),
      .peripheral_time_base(peripheral_time_base),
      .low_power_rc_tick(low_power_rc_tick)
   );

   // 125 MHz system clock
   always #4 clk_sys = ~clk_sys;

   // Primary oscillator stand-in with a 26-cycle period
   always @(posedge clk_sys) begin
      if (osc_run) begin
         pin_cnt <= (pin_cnt == 12) ? 0 : pin_cnt + 1;
         if (pin_cnt == 12) osc_in_pin <= ~osc_in_pin;
      end
   end

   task automatic final_report;
      $display("Comparisons %0d, mismatches %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : final_report

   task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                        input string what);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR at %0t ns: %s seen %h expected %h", $time, what,
                  seen, exp);
      end
   endtask : check

   function automatic logic [31:0] near(input int seen, input real exp,
                                        input real tol);
      return (seen >= exp - tol && seen <= exp + tol) ? 32'h1 : 32'h0;
   endfunction : near

   // Power-on reset with a configuration word held across release
   task automatic do_reset(input logic [5:0] c);
      @(posedge clk_sys);
      rst_n <= 1'b0;
      bus_req <= '0;
      cfg_word <= scss_cfg_word_t'(c);
      repeat (16) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk_sys);
   endtask : do_reset

   task automatic bus_wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk_sys);
      bus_req <= '0;
   endtask : bus_wr

   // Read data stand only in the cycle after the strobe
   task automatic bus_rd(input logic [7:0] a, output logic [15:0] d);
      @(posedge clk_sys);
      bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
      @(posedge clk_sys);
      bus_req <= '0;
      #1 d = bus_rdata;
      @(posedge clk_sys);
      #1 check(bus_rdata, 16'h0000, "read data not cleared");
   endtask : bus_rd

   // Counts oscillator, instruction and low-power pulses over a window
   task automatic measure(input int cyc);
      logic prev;
      n_osc = 0;
      n_ins = 0;
      n_rise = 0;
      n_lp = 0;
      n_bad = 0;
      prev = instruction_clock;
      repeat (cyc) begin
         @(posedge clk_sys);
         #1;
         n_osc += (oscillator_output_clock === 1'b1);
         n_ins += (instr_tick === 1'b1);
         n_lp += (low_power_rc_tick === 1'b1);
         n_rise += (instruction_clock === 1'b1 && prev === 1'b0);
         n_bad += (peripheral_time_base !== instruction_clock);
         prev = instruction_clock;
      end
      check(n_bad, 0, "time base differs");
      check(near(n_rise, n_osc / 2.0, 1.0), 1, "instr clock rate");
      check(near(n_ins, n_rise, 1.0), 1, "instr tick count");
   endtask : measure

   // Erased configuration, then a late change of the configuration word
   task automatic t_erased;
      do_reset(6'h3F);
      bus_rd(`SCSS_ADDR_STATUS, rd);
      check(rd, 16'h0C37, "erased status");
      measure(3000);
      check(near(n_osc, 3000 * FAST_RC_OSC / 2, 1), 1, "erased rate");
      @(posedge clk_sys);
      cfg_word <= '0;
      bus_rd(`SCSS_ADDR_STATUS, rd);
      check(rd, 16'h0C37, "selection not held");
      measure(3000);
      check(near(n_osc, 3000 * FAST_RC_OSC / 2, 1), 1, "held rate");
   endtask : t_erased

   // Every post-divider setting, read back and rate
   task automatic t_postdiv;
      int win;
      logic ic;
      do_reset(6'h07);
      for (int f = 0; f < 8; f++) begin
         bus_wr(`SCSS_ADDR_CLOCK_DIVISOR, {5'h1F, 3'(f), 8'hFF});
         bus_rd(`SCSS_ADDR_CLOCK_DIVISOR, rd);
         check(rd, {5'h00, 3'(f), 8'h00}, "divisor readback");
         win = int'(3.0 * (2 << f) / FAST_RC_OSC);
         measure(win);
         check(near(n_osc, 3.0, 1.0), 1, "divided rate");
      end
      check(osc_out_oe_n, 1'b0, "second pin not driven");
      // Second pin carries the instruction clock one cycle late
      repeat (40) begin
         @(posedge clk_sys);
         #1 ic = instruction_clock;
         @(posedge clk_sys);
         #1 check(osc_out_o, ic, "second pin clock");
      end
   endtask : t_postdiv

   // Internal choices with alternate bit set and primary mode ignored
   task automatic t_modes;
      logic [2:0] ch [5] = '{3'h0, 3'h1, 3'h6, 3'h5, 3'h4};
      real rate [5];
      real e;
      rate = '{FAST_RC_OSC, FAST_RC_OSC * 8, FAST_RC_OSC / 16, LPR, 0.0};
      for (int i = 0; i < 5; i++) begin
         do_reset({1'b1, 2'b10, ch[i]});
         bus_rd(`SCSS_ADDR_STATUS, rd);
         check(rd, {4'h0, 2'b11, ch[i] == 3'h4, ch[i] == 3'h1, 4'h2, 1'b0,
                    ch[i]}, "status");
         measure(3000);
         e = 3000 * rate[i];
         check(near(n_osc, e, 1 + e / 50), 1, "mode rate");
         check(near(n_lp, 3000 * LPR, 1), 1, "low-power tick");
         check(osc_out_oe_n, 1'b1, "second pin released");
         check(osc_out_o, 1'b0, "released pin value");
      end
   endtask : t_modes

   // Primary oscillator modes, direct and through the PLL
   task automatic t_primary;
      logic [5:0] pc [6] = '{6'h02, 6'h22, 6'h0A, 6'h33, 6'h03, 6'h1A};
      int mul [6] = '{1, 1, 1, 8, 8, 0};
      int xt [6] = '{0, 0, 1, 1, 0, 2};
      logic oe [6] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
      real e;
      osc_run <= 1'b1;
      for (int i = 0; i < 6; i++) begin
         do_reset(pc[i]);
         repeat (100) @(posedge clk_sys);
         measure(3000);
         e = 3000.0 * mul[i] / 26;
         check(near(n_osc, e, 2 + e / 50), 1, "primary rate");
         if (xt[i] != 2)
            check(xtal_drive_en, xt[i][0], "crystal drive");
         check(osc_out_oe_n, oe[i], "second pin enable");
      end
      osc_run <= 1'b0;
   endtask : t_primary

   // Tuning in both directions, refused writes and unmapped places
   task automatic t_tune;
      do_reset(6'h00);
      bus_wr(`SCSS_ADDR_TUNE, 16'hFFDF);
      bus_rd(`SCSS_ADDR_TUNE, rd);
      check(rd, 16'h001F, "tune readback");
      measure(3000);
      check(near(n_osc, 3000 * FAST_RC_OSC * 543 / 512, 2), 1, "tuned up");
      bus_wr(`SCSS_ADDR_TUNE, 16'h0020);
      bus_rd(`SCSS_ADDR_TUNE, rd);
      check(rd, 16'h0020, "tune readback");
      measure(3000);
      check(near(n_osc, 3000 * FAST_RC_OSC * 480 / 512, 2), 1, "tuned down");
      bus_wr(`SCSS_ADDR_STATUS, 16'hFFFF);
      bus_wr(8'h0C, 16'hFFFF);
      bus_rd(`SCSS_ADDR_STATUS, rd);
      check(rd, 16'h0800, "status written");
      bus_rd(8'h0C, rd);
      check(rd, 16'h0000, "unmapped read");
      bus_rd(`SCSS_ADDR_CLOCK_DIVISOR, rd);
      check(rd, 16'h0000, "divisor disturbed");
   endtask : t_tune

   // Watchdog against a hung run
   initial begin
      repeat (95000) @(posedge clk_sys);
      fails++;
      $display("ERROR at %0t ns: run timed out", $time);
      final_report();
   end

   // Main sequence
   initial begin
      t_erased();
      t_postdiv();
      t_modes();
      t_primary();
      t_tune();
      final_report();
   end
endmodule : scss_source_select_tb
`default_nettype wire
